// ==== hdl/tvic_pkg.sv ====
`default_nettype none
package tvic_pkg;
	// ==========================================================
	// sources, in fixed polling order (index 0 polled first)
	localparam int NSRC = 7;
	localparam int SRC_DSP = 0;
	localparam int SRC_TMR0 = 1;
	localparam int SRC_GPIO = 2;
	localparam int SRC_SPI = 3;
	localparam int SRC_UART1 = 4;
	localparam int SRC_UART2 = 5;
	localparam int SRC_CAL = 6;
	localparam int GATE_BIT = 7;
	// ==========================================================
	// vector addresses
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	// ==========================================================
	// register byte addresses on the bus
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_LEVEL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_LEVEL = 8'h00;
	localparam logic [1:0] RST_EVT = 2'h0;
	// interrupt event bits
	localparam int EVT_TAKEN = 0;
	localparam int EVT_RETURN = 1;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {TVIC_IDLE, TVIC_LOW, TVIC_HIGH, TVIC_HL}
		tvic_state_e;
endpackage
`default_nettype wire

// ==== hdl/tvic_ctrl.sv ====
`default_nettype none
`default_nettype wire

// ==== hdl/tvic_top.sv ====
`default_nettype none
// Behaviour
// - seven independent request sources are collected.
// - an accepted request presents that source's fixed vector to the core.
// - the enable register holds one enable per source, gate at bit 7.
// - a clear gate blocks all requests, else each follows its enable bit.
// - the level register holds one high/low bit per source, bit 7 unused.
// - in a low routine only a high request may still be delivered.
// - in a high routine nothing further is delivered.
// - a pending high request is taken before a pending low one.
// - same-level ties poll DSP, timer0, gpio, spi, uart1, uart2, cal.
// - each source request is the OR of that peripheral's flags.
module tvic_top
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// peripheral flags
	input wire logic [3:0] calendar_flags,
	input wire logic [1:0] uart1_flags,
	input wire logic [1:0] uart2_flags,
	input wire logic serial_transfer_done_flag,
	input wire logic [1:0] gpio_status_flags,
	input wire logic timer0_overflow_flag,
	input wire logic [1:0] meter_flags,
	// core side
	output logic core_irq_req,
	output logic [15:0] core_irq_vector,
	input wire logic core_irq_ack,
	input wire logic core_reti,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt to system
	output logic irq
);
	// ==========================================================
	// request gathering
	logic [6:0] src_req;
	logic [7:0] enable_q;
	logic [7:0] level_q;
	logic [6:0] active_req;
	logic [6:0] hi_req;
	logic [6:0] lo_req;
	logic [6:0] pick;
	logic [2:0] pick_idx;
	logic pick_hi;
	logic can_hi;
	logic can_lo;
	logic [2:0] idx_q;
	logic req_q;
	logic hi_q;
	tvic_pkg::tvic_state_e state_q;
	logic [1:0] evt_q;
	logic [1:0] mask_q;

	// lowest set index wins: fixed polling order
	function automatic logic [2:0] first_idx(input logic [6:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = tvic_pkg::NSRC - 1; i >= 0; i--)
			if (v[i])
				r = 3'(i);
		return r;
	endfunction

	// flags come from core-clock logic, so no synchroniser
	always_comb
	begin
		src_req[tvic_pkg::SRC_CAL] = |calendar_flags;
		src_req[tvic_pkg::SRC_UART2] = |uart2_flags;
		src_req[tvic_pkg::SRC_UART1] = |uart1_flags;
		src_req[tvic_pkg::SRC_SPI] = serial_transfer_done_flag;
		src_req[tvic_pkg::SRC_GPIO] = |gpio_status_flags;
		src_req[tvic_pkg::SRC_TMR0] = timer0_overflow_flag;
		src_req[tvic_pkg::SRC_DSP] = |meter_flags;
	end

	// gate, per-source enables, then split by level
	assign active_req = enable_q[tvic_pkg::GATE_BIT] ?
		(src_req & enable_q[6:0]) : 7'h00;
	assign hi_req = active_req & level_q[6:0];
	assign lo_req = active_req & ~level_q[6:0];

	// ==========================================================
	// nesting state and arbitration
	assign can_hi = (state_q == tvic_pkg::TVIC_IDLE) ||
		(state_q == tvic_pkg::TVIC_LOW);
	assign can_lo = (state_q == tvic_pkg::TVIC_IDLE);
	assign pick_hi = can_hi && (hi_req != 7'h00);
	assign pick = pick_hi ? hi_req : (can_lo ? lo_req : 7'h00);
	assign pick_idx = first_idx(pick);

	// offer is registered; the vector is re-picked every cycle while requested
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			req_q <= 1'b0;
			idx_q <= 3'h0;
			hi_q <= 1'b0;
		end
		else if (core_irq_ack || core_reti)
			req_q <= 1'b0; // re-evaluate after every state change
		else
		begin
			req_q <= pick != 7'h00;
			idx_q <= pick_idx;
			hi_q <= pick_hi;
		end
	end
	assign core_irq_req = req_q;
	assign core_irq_vector = tvic_pkg::VEC_BASE +
		16'(idx_q) * tvic_pkg::VEC_STEP;

	// active-level tracking; ack enters, return leaves innermost level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= tvic_pkg::TVIC_IDLE;
		else if (core_irq_ack && req_q)
		begin
			case (state_q)
				tvic_pkg::TVIC_IDLE:
					state_q <= hi_q ? tvic_pkg::TVIC_HIGH : tvic_pkg::TVIC_LOW;
				tvic_pkg::TVIC_LOW: state_q <= tvic_pkg::TVIC_HL;
				default: state_q <= state_q;
			endcase
		end
		else if (core_reti)
		begin
			case (state_q)
				tvic_pkg::TVIC_HL: state_q <= tvic_pkg::TVIC_LOW;
				default: state_q <= tvic_pkg::TVIC_IDLE;
			endcase
		end
	end

	// ==========================================================
	// axi4-lite slave: one write, one read at a time
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_val;
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// capture address and data in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (wr_go)
				w_q <= 1'b0;
		end
	end

	assign wr_ok = awaddr_q == tvic_pkg::OFS_ENABLE ||
		awaddr_q == tvic_pkg::OFS_LEVEL ||
		awaddr_q == tvic_pkg::OFS_IRQ_STAT ||
		awaddr_q == tvic_pkg::OFS_IRQ_MASK;

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tvic_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? tvic_pkg::RESP_OKAY : tvic_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// enable, level and mask registers, byte lane 0 only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable_q <= tvic_pkg::RST_ENABLE;
			level_q <= tvic_pkg::RST_LEVEL;
			mask_q <= tvic_pkg::RST_EVT;
		end
		else if (wr_go && wstrb_q[0])
		begin
			if (awaddr_q == tvic_pkg::OFS_ENABLE)
				enable_q <= wdata_q[7:0];
			if (awaddr_q == tvic_pkg::OFS_LEVEL)
				level_q <= {1'b0, wdata_q[6:0]};
			if (awaddr_q == tvic_pkg::OFS_IRQ_MASK)
				mask_q <= wdata_q[1:0];
		end
	end

	// sticky events: set wins over a write-one clear
	logic [1:0] evt_clr;
	logic [1:0] evt_set;
	assign evt_clr = (wr_go && wstrb_q[0] &&
		awaddr_q == tvic_pkg::OFS_IRQ_STAT) ? wdata_q[1:0] : 2'h0;
	assign evt_set = {core_reti, core_irq_ack && req_q};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			evt_q <= tvic_pkg::RST_EVT;
		else
			evt_q <= (evt_q & ~evt_clr) | evt_set;
	end
	assign irq = |(evt_q & mask_q);

	// read mux
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			tvic_pkg::OFS_ENABLE: rd_val = {24'h0, enable_q};
			tvic_pkg::OFS_LEVEL: rd_val = {24'h0, level_q};
			tvic_pkg::OFS_STATUS:
				rd_val = {13'h0, idx_q, 2'(state_q), 7'h00, src_req};
			tvic_pkg::OFS_IRQ_STAT: rd_val = {30'h0, evt_q};
			tvic_pkg::OFS_IRQ_MASK: rd_val = {30'h0, mask_q};
			default:
			begin
				rd_val = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	// read response, one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= tvic_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? tvic_pkg::RESP_OKAY : tvic_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// checks
	sequence s_ack_high;
		core_irq_ack && req_q && hi_q;
	endsequence
	AST_GATE_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
		!enable_q[7] |=> !core_irq_req)
		else $error("request offered while gate clear");
	AST_HIGH_NO_NEST: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ack_high ##1 (!core_reti)[*2] |-> !core_irq_req)
		else $error("request offered inside high routine");
	AST_LOW_NEST_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == tvic_pkg::TVIC_LOW && core_irq_req) |-> hi_q)
		else $error("low request offered inside low routine");
	AST_HIGH_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
		(can_hi && hi_req != 7'h00 && !core_irq_ack && !core_reti)
		|=> core_irq_req && hi_q)
		else $error("high request not preferred");
	AST_POLL_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
		(pick[0] && !core_irq_ack && !core_reti) |=> idx_q == 3'h0)
		else $error("polling order broken");
	AST_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
		core_irq_req && idx_q == 3'h6 |-> core_irq_vector == 16'h0033)
		else $error("wrong vector");
	AST_RETI_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_reti && !core_irq_ack && state_q != tvic_pkg::TVIC_HL)
		|=> state_q == tvic_pkg::TVIC_IDLE)
		else $error("level not released");
	AST_LEVEL_B7: assert property (@(posedge aclk) disable iff (!aresetn)
		!level_q[7])
		else $error("level bit 7 set");
	AST_FLAG_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
		(enable_q == 8'h82 && timer0_overflow_flag && state_q ==
		tvic_pkg::TVIC_IDLE && !core_irq_ack && !core_reti)
		|=> core_irq_req && idx_q == 3'h1)
		else $error("timer flag not requested");
endmodule
`default_nettype wire

// ==== tb/tvic_core_model.sv ====
`default_nettype none
// stand-in for the cpu core: takes one offer on command, returns on command
module tvic_core_model
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// controller side
	input wire logic core_irq_req,
	input wire logic [15:0] core_irq_vector,
	output logic core_irq_ack,
	output logic core_reti,
	// bench side
	input wire logic take,
	input wire logic ret_cmd,
	output logic took,
	output logic [15:0] last_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	// ack is one pulse per offer; took guards against a second ack
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_irq_ack <= 1'h0;
			core_reti <= 1'h0;
			took <= 1'h0;
			last_vec <= 16'h0000;
		end
		else
		begin
			core_irq_ack <= take && core_irq_req && !core_irq_ack && !took;
			took <= core_irq_ack && core_irq_req;
			if (core_irq_ack && core_irq_req)
				last_vec <= core_irq_vector;
			core_reti <= ret_cmd;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0;
	logic aresetn, req, ack, reti, irq, take, ret_cmd, took;
	logic [15:0] vec, last_vec;
	logic [13:0] fl;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, lresp;
	int miscompares, cmp_count;
	// first bit of each source in the packed flag vector
	localparam int LO[8] = '{0, 2, 3, 5, 6, 8, 10, 14};
	always #2.5 aclk = ~aclk;
	// flag vector is sliced per peripheral
	tvic_top dut_u (.aclk(aclk), .aresetn(aresetn),
		.calendar_flags(fl[13:10]), .uart1_flags(fl[7:6]),
		.uart2_flags(fl[9:8]), .serial_transfer_done_flag(fl[5]),
		.gpio_status_flags(fl[4:3]), .timer0_overflow_flag(fl[2]),
		.meter_flags(fl[1:0]), .core_irq_req(req), .core_irq_vector(vec),
		.core_irq_ack(ack), .core_reti(reti), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));
	tvic_core_model core_u (.aclk(aclk), .aresetn(aresetn),
		.core_irq_req(req), .core_irq_vector(vec), .core_irq_ack(ack),
		.core_reti(reti), .take(take), .ret_cmd(ret_cmd), .took(took),
		.last_vec(last_vec));
	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic fail(input string m);
		miscompares++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
			fail($sformatf("value %h expected %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		cmp_count++;
		if (g !== e)
			fail($sformatf("flag %b expected %b", g, e));
	endtask
	// bus tasks: sample at the falling edge, act after the rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		b = 1'h0;
		n = 0;
		while (!b && n < 50)
		begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid === 1'h1;
			lresp = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'h0;
			if (w)
				wvalid <= 1'h0;
			n++;
		end
		if (!b)
			fail("no write response");
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar, r;
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		r = 1'h0;
		n = 0;
		while (!r && n < 50)
		begin
			@(negedge aclk);
			ar = arvalid && arready;
			r = rvalid === 1'h1;
			rdat = rdata;
			lresp = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 1'h0;
			n++;
		end
		if (!r)
			fail("no read response");
	endtask
	// core accepts the next offer, which must carry source s
	task automatic serve(input int s);
		int n;
		take <= 1'h1;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (took !== 1'h1 && n < 30);
		if (took !== 1'h1)
			fail("no offer taken");
		chk_val({16'h0000, last_vec},
			32'(tvic_pkg::VEC_BASE + tvic_pkg::VEC_STEP * s));
		@(posedge aclk);
		take <= 1'h0;
		// let an edge pass so a following call may raise take again
		@(posedge aclk);
	endtask
	task automatic no_req(input int c);
		logic seen;
		seen = 1'h0;
		repeat (c)
		begin
			@(negedge aclk);
			if (req !== 1'h0)
				seen = 1'h1;
		end
		@(posedge aclk);
		chk_bit(seen, 1'h0);
	endtask
	task automatic ret();
		ret_cmd <= 1'h1;
		@(posedge aclk);
		ret_cmd <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge aclk);
		chk_bit(irq, e);
		@(posedge aclk);
	endtask
	function automatic logic [13:0] bits(input int s);
		return 14'((15'h0001 << LO[s + 1]) - (15'h0001 << LO[s]));
	endfunction
	// watchdog: the whole sequence needs a few hundred cycles
	initial
	begin
		#200000;
		fail("timeout");
		test_done();
	end
	initial
	begin
		aresetn = 1'h0;
		{fl, take, ret_cmd, awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, arvalid} = '0;
		// response readies stay high: every answer is taken at once
		{bready, rready} = 2'h3;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(tvic_pkg::OFS_ENABLE);
		chk_val(rdat, 32'h00000000);
		rd(tvic_pkg::OFS_LEVEL);
		chk_val(rdat, 32'h00000000);
		wr(tvic_pkg::OFS_LEVEL, 32'h000000FF);
		chk_val({30'h0, lresp}, {30'h0, tvic_pkg::RESP_OKAY});
		rd(tvic_pkg::OFS_LEVEL);
		chk_val(rdat, 32'h0000007F);
		rd(8'h40);
		chk_val({rdat[29:0], lresp}, {30'h0, tvic_pkg::RESP_SLVERR});
		wr(8'h44, 32'h00000001);
		chk_val({30'h0, lresp}, {30'h0, tvic_pkg::RESP_SLVERR});
		wr(tvic_pkg::OFS_LEVEL, 32'h00000000);
		$display("test registers done");
		fl <= bits(1);
		wr(tvic_pkg::OFS_ENABLE, 32'h00000002);
		no_req(8);
		wr(tvic_pkg::OFS_ENABLE, 32'h00000082);
		serve(1);
		fl <= 14'h0000;
		ret();
		$display("test gate done");
		// every single flag raises its own source's vector
		for (int j = 0; j < 14; j++)
		begin
			int s;
			s = 0;
			while (LO[s + 1] <= j)
				s++;
			fl <= 14'(1 << j);
			wr(tvic_pkg::OFS_ENABLE, 32'(8'h80 | (1 << s)));
			serve(s);
			fl <= 14'h0000;
			ret();
		end
		$display("test vectors done");
		wr(tvic_pkg::OFS_ENABLE, 32'h000000FD);
		rd(tvic_pkg::OFS_ENABLE);
		chk_val(rdat, 32'h000000FD);
		fl <= 14'h3FFF;
		for (int s = 0; s < 7; s++)
			if (s != 1)
			begin
				serve(s);
				no_req(4);
				fl <= fl & ~bits(s);
				ret();
			end
		no_req(4);
		$display("test polling done");
		wr(tvic_pkg::OFS_LEVEL, 32'h00000042);
		wr(tvic_pkg::OFS_ENABLE, 32'h000000FF);
		fl <= 14'h3FFF;
		serve(1);
		no_req(4);
		fl <= fl & ~bits(1);
		ret();
		serve(6);
		no_req(4);
		fl <= fl & ~bits(6);
		ret();
		serve(0);
		fl <= fl | bits(1);
		serve(1);
		fl <= fl & ~bits(1);
		ret();
		no_req(4);
		fl <= 14'h0000;
		ret();
		$display("test levels done");
		wr(tvic_pkg::OFS_LEVEL, 32'h00000000);
		wr(tvic_pkg::OFS_IRQ_MASK, 32'h00000000);
		wr(tvic_pkg::OFS_IRQ_STAT, 32'h00000003);
		rd(tvic_pkg::OFS_IRQ_STAT);
		chk_val(rdat, 32'h00000000);
		wr(tvic_pkg::OFS_ENABLE, 32'h00000082);
		fl <= bits(1);
		serve(1);
		rd(tvic_pkg::OFS_IRQ_STAT);
		chk_val(rdat, 32'h00000001);
		// low routine active, no offer pending, raw timer request seen
		rd(tvic_pkg::OFS_STATUS);
		chk_val(rdat, 32'h00004002);
		chk_irq(1'h0);
		wr(tvic_pkg::OFS_IRQ_MASK, 32'h00000001);
		chk_irq(1'h1);
		wr(tvic_pkg::OFS_IRQ_STAT, 32'h00000001);
		chk_irq(1'h0);
		fl <= 14'h0000;
		ret();
		rd(tvic_pkg::OFS_IRQ_STAT);
		chk_val(rdat, 32'h00000002);
		$display("test events done");
		test_done();
	end
endmodule
`default_nettype wire
